// ---- shared/frwar_pkg.sv ----
// Constants and types for the flash register-write and array-read command block
// Contract
// - Status write needs write latch set first
// - Status write updates protect bits, disable bit
// - Serial status write ends at 8/16 bits
// - Double-rate write must end with clock low
// - Register write cycle starts on select rise
// - Busy during cycle; end clears busy, latch
// - Status register readable while busy
// - Second config read while busy returns only checksum error bit
// - Second config read: opcode, four-byte address
// - Second config write needs write latch
// - Second config write ends at 8 bits
// - Security register readable anytime, repeatedly
// - Security write needs write latch
// - Lockdown bit set blocks further updates
// - Security write ends exactly at opcode boundary
// - Address on rising edge, data on falling
// - Read address increments, wraps to zero
// - Three or four address bytes by opcode
// - Select rise ends read output
// - Quick read has eight dummy clocks
// - Quick read rejected while busy
// - Write-enable command sets write latch
`default_nettype none
package frwar_pkg;
  // Default opcodes; the module takes them as parameters
  localparam logic [7:0] FRWAR_OP_WRITE_LATCH_SET_CMD = 8'h06;
  localparam logic [7:0] FRWAR_OP_RDSR = 8'h05;
  localparam logic [7:0] FRWAR_OP_STATUS_REG_WRITE_CMD = 8'h01;
  localparam logic [7:0] FRWAR_OP_SECOND_CONFIG_READ_CMD = 8'h71;
  localparam logic [7:0] FRWAR_OP_SECOND_CONFIG_WRITE_CMD = 8'h72;
  localparam logic [7:0] FRWAR_OP_SECURITY_REG_READ_CMD = 8'h2b;
  localparam logic [7:0] FRWAR_OP_SECURITY_REG_WRITE_CMD = 8'h2f;
  localparam logic [7:0] FRWAR_OP_RD3 = 8'h03;
  localparam logic [7:0] FRWAR_OP_RD4 = 8'h13;
  localparam logic [7:0] FRWAR_OP_FRD3 = 8'h0b;
  localparam logic [7:0] FRWAR_OP_FRD4 = 8'h0c;
  // Status register bit positions
  localparam int FRWAR_SR_BUSY = 0;
  localparam int FRWAR_SR_WEL = 1;
  localparam int FRWAR_SR_STATUS_WRITE_DISABLE_BIT = 7;
  localparam logic [7:0] FRWAR_SR_WMASK = 8'hbc;
  // Security register lockdown position and checksum error bit of config 2
  localparam int FRWAR_SEC_LOCK = 1;
  localparam int FRWAR_CR2_CHECKSUM_ERROR_BIT = 7;
  // Bit counts of the serial phases
  localparam logic [5:0] FRWAR_BITS_OP = 6'h08;
  localparam logic [5:0] FRWAR_BITS_A3 = 6'h18;
  localparam logic [5:0] FRWAR_BITS_A4 = 6'h20;
  localparam logic [5:0] FRWAR_BITS_DUMMY = 6'h08;
  localparam logic [5:0] FRWAR_BITS_SR1 = 6'h10;
  localparam logic [5:0] FRWAR_BITS_SR2 = 6'h18;
  // Opcode, four address bytes and one data byte
  localparam logic [5:0] FRWAR_BITS_CR2 = 6'h30;
  // Register write cycle time
  localparam int FRWAR_TW_NS = 40000;
  localparam int FRWAR_CLK_NS = 5;
  localparam int FRWAR_TW_CYC = FRWAR_TW_NS / FRWAR_CLK_NS;
  // Command decoder states
  typedef enum logic [5:0] {
    FRWAR_OPC = 6'b000001,
    FRWAR_ADDR = 6'b000010,
    FRWAR_DUMMY = 6'b000100,
    FRWAR_DOUT = 6'b001000,
    FRWAR_WDATA = 6'b010000,
    FRWAR_IGNORE = 6'b100000
  } frwar_state_e;
endpackage
`default_nettype wire

// ---- hdl/frwar_fifo.sv ----
// Small first-word-fall-through FIFO for read data
`default_nettype none
module frwar_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp;
  logic [AW:0] rp;
  wire do_push = in_valid && in_ready;
  wire do_pop = out_valid && out_ready;
  // Honest full and empty from pointer compare
  assign in_ready = (wp - rp) != (AW+1)'(DEPTH);
  assign out_valid = wp != rp;
  assign out_data = mem[rp[AW-1:0]];
  // Pointers; flush empties on select rise
  always_ff @(posedge clk)
  begin
    if (!nrst || flush)
    begin
      wp <= '0;
      rp <= '0;
    end
    else
    begin
      if (do_push)
        wp <= wp + 1'b1;
      if (do_pop)
        rp <= rp + 1'b1;
    end
  end
  always_ff @(posedge clk)
  begin
    if (do_push)
      mem[wp[AW-1:0]] <= in_data;
  end
endmodule
`default_nettype wire

// ---- hdl/frwar_core.sv ----
// Serial flash command block: register writes and array reads
`default_nettype none
module frwar_core
  import frwar_pkg::*;
#(
  parameter logic [7:0] OP_WRITE_LATCH_SET_CMD = FRWAR_OP_WRITE_LATCH_SET_CMD,
  parameter logic [7:0] OP_RDSR = FRWAR_OP_RDSR,
  parameter logic [7:0] OP_STATUS_REG_WRITE_CMD = FRWAR_OP_STATUS_REG_WRITE_CMD,
  parameter logic [7:0] OP_SECOND_CONFIG_READ_CMD = FRWAR_OP_SECOND_CONFIG_READ_CMD,
  parameter logic [7:0] OP_SECOND_CONFIG_WRITE_CMD = FRWAR_OP_SECOND_CONFIG_WRITE_CMD,
  parameter logic [7:0] OP_SECURITY_REG_READ_CMD = FRWAR_OP_SECURITY_REG_READ_CMD,
  parameter logic [7:0] OP_SECURITY_REG_WRITE_CMD = FRWAR_OP_SECURITY_REG_WRITE_CMD,
  parameter logic [7:0] OP_RD3 = FRWAR_OP_RD3,
  parameter logic [7:0] OP_RD4 = FRWAR_OP_RD4,
  parameter logic [7:0] OP_FRD3 = FRWAR_OP_FRD3,
  parameter logic [7:0] OP_FRD4 = FRWAR_OP_FRD4,
  parameter logic [31:0] CR2_ADDR = 32'h00000000,
  parameter int ADDR_W = 26,
  parameter int TW_CYC = FRWAR_TW_CYC,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Serial link pins, asynchronous to clk
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // Mode select: double-rate octal end check
  input wire logic octal_double_rate_mode,
  // Array storage read port
  output logic [ADDR_W-1:0] mem_addr,
  output logic mem_req,
  input wire logic mem_ack,
  input wire logic [7:0] mem_data,
  // Register contents
  output logic [7:0] status_reg,
  output logic [7:0] config_reg,
  output logic [7:0] config2_reg,
  output logic [7:0] security_reg,
  input wire logic checksum_error_bit,
  // Command events
  output logic cmd_rejected
);
  // Two-flop synchronisers; first stage read only by second
  logic [1:0] sclk_s;
  logic [1:0] cs_s;
  logic [1:0] si_s;
  logic sclk_d;
  logic cs_d;
  always_ff @(posedge clk)
  begin
    sclk_s <= {sclk_s[0], sclk};
    cs_s <= {cs_s[0], cs_n};
    si_s <= {si_s[0], si};
  end
  always_ff @(posedge clk)
  begin
    sclk_d <= sclk_s[1];
    cs_d <= cs_s[1];
  end
  wire sel = !cs_s[1];
  wire rise = sel && sclk_s[1] && !sclk_d;
  wire fall = sel && !sclk_s[1] && sclk_d;
  wire cs_rise = cs_s[1] && !cs_d;
  wire cs_fall = !cs_s[1] && cs_d;

  frwar_state_e state;
  frwar_state_e next_state;
  logic [7:0] opcode;
  logic [5:0] nbits;
  logic [31:0] shreg;
  logic [ADDR_W-1:0] addr;
  logic [7:0] out_byte;
  logic [2:0] out_cnt;
  logic busy;
  logic write_latch_bit;
  logic [7:0] sr_bits;
  logic [31:0] tw_cnt;
  logic [7:0] pend_sr;
  logic [7:0] pend_cr;
  logic pend_sr_wr;
  logic pend_cr_wr;

  // Opcode classes
  wire [7:0] op_now = {shreg[6:0], si_s[1]};
  wire is_rd = opcode == OP_RD3 || opcode == OP_RD4;
  wire is_frd = opcode == OP_FRD3 || opcode == OP_FRD4;
  wire is_four = opcode == OP_RD4 || opcode == OP_FRD4 || opcode == OP_SECOND_CONFIG_READ_CMD;
  wire [5:0] addr_bits = is_four ? FRWAR_BITS_A4 : FRWAR_BITS_A3;
  wire wr_sr = opcode == OP_STATUS_REG_WRITE_CMD;
  wire wr_cr2 = opcode == OP_SECOND_CONFIG_WRITE_CMD;
  wire wr_sec = opcode == OP_SECURITY_REG_WRITE_CMD;
  // Exact-boundary tests at select rise, in bits counted from opcode start
  wire sr_ok = nbits == FRWAR_BITS_SR1 || nbits == FRWAR_BITS_SR2;
  wire cr2_ok = nbits == FRWAR_BITS_CR2;
  wire sec_ok = nbits == FRWAR_BITS_OP;
  // Double-rate mode: the select must rise while the clock sits low
  wire edge_ok = !octal_double_rate_mode || !sclk_s[1];
  // A write ended while busy still counts as ended, so its refusal is visible
  wire end_write = cs_rise && (wr_sr || wr_cr2 || wr_sec);
  wire good_sr = wr_sr && sr_ok && edge_ok && write_latch_bit;
  wire good_cr2 = wr_cr2 && cr2_ok && edge_ok && write_latch_bit;
  wire good_sec = wr_sec && sec_ok && edge_ok && write_latch_bit
    && !security_reg[FRWAR_SEC_LOCK];
  wire tw_done = busy && tw_cnt == 32'(TW_CYC - 1);

  // Read data path through the FIFO
  logic f_in_valid;
  logic f_in_ready;
  logic f_out_valid;
  logic f_out_ready;
  logic [7:0] f_out_data;
  logic [7:0] reg_byte;
  logic reg_src;
  frwar_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .flush(cs_rise),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(reg_src ? reg_byte : mem_data),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );
  // Register reads repeat their byte; array reads fetch from storage
  assign reg_src = !(is_rd || is_frd);
  always_comb
  begin
    reg_byte = status_reg;
    if (opcode == OP_SECURITY_REG_READ_CMD)
      reg_byte = security_reg;
    else if (opcode == OP_SECOND_CONFIG_READ_CMD)
      reg_byte = busy ? {checksum_error_bit, 7'h00} : config2_reg;
    else if (opcode == OP_RDSR)
      reg_byte = status_reg;
  end
  wire data_phase = state == FRWAR_DOUT;
  assign mem_req = data_phase && !reg_src && f_in_ready;
  assign f_in_valid = data_phase && (reg_src ? 1'b1 : mem_ack);
  // Next byte is loaded on the falling edge that completes the last
  assign f_out_ready = data_phase && fall && out_cnt == 3'h7;

  // Command state machine
  always_comb
  begin
    next_state = state;
    unique case (state)
      FRWAR_OPC:
        if (rise && nbits == FRWAR_BITS_OP - 6'h01)
        begin
          if (op_now == OP_WRITE_LATCH_SET_CMD || op_now == OP_SECURITY_REG_WRITE_CMD)
            next_state = FRWAR_IGNORE;
          else if (op_now == OP_RDSR || op_now == OP_SECURITY_REG_READ_CMD)
            next_state = FRWAR_DOUT;
          else if ((op_now == OP_FRD3 || op_now == OP_FRD4) && busy)
            next_state = FRWAR_IGNORE;
          else if (op_now == OP_SECOND_CONFIG_READ_CMD || op_now == OP_RD3 || op_now == OP_RD4
                   || op_now == OP_FRD3 || op_now == OP_FRD4)
            next_state = FRWAR_ADDR;
          else if (op_now == OP_STATUS_REG_WRITE_CMD || op_now == OP_SECOND_CONFIG_WRITE_CMD)
            next_state = FRWAR_WDATA;
          else
            next_state = FRWAR_IGNORE;
        end
      FRWAR_ADDR:
        if (rise && nbits == FRWAR_BITS_OP + addr_bits - 6'h01)
          next_state = is_frd ? FRWAR_DUMMY : FRWAR_DOUT;
      FRWAR_DUMMY:
        if (rise && nbits == FRWAR_BITS_OP + addr_bits + FRWAR_BITS_DUMMY - 6'h01)
          next_state = FRWAR_DOUT;
      FRWAR_DOUT: next_state = FRWAR_DOUT;
      FRWAR_WDATA: next_state = FRWAR_WDATA;
      FRWAR_IGNORE: next_state = FRWAR_IGNORE;
      default: next_state = FRWAR_IGNORE;
    endcase
    if (!sel)
      next_state = FRWAR_OPC;
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
      state <= FRWAR_OPC;
    else
      state <= next_state;
  end

  // Bit counter and input shift register
  always_ff @(posedge clk)
  begin
    if (!nrst || cs_fall)
    begin
      nbits <= '0;
      shreg <= '0;
    end
    else if (rise && nbits != 6'h3f)
    begin
      nbits <= nbits + 6'h01;
      shreg <= {shreg[30:0], si_s[1]};
    end
  end
  // Opcode capture; cleared per frame so an empty frame cannot replay the last command
  always_ff @(posedge clk)
  begin
    if (!nrst || cs_fall)
      opcode <= '0;
    else if (state == FRWAR_OPC && rise && nbits == FRWAR_BITS_OP - 6'h01)
      opcode <= op_now;
  end

  // Address counter: load after address phase, step per byte, wrap at top
  always_ff @(posedge clk)
  begin
    if (!nrst)
      addr <= '0;
    else if (sel && state == FRWAR_ADDR && next_state != FRWAR_ADDR)
      addr <= is_four ? ADDR_W'({shreg[30:0], si_s[1]})
        : ADDR_W'({shreg[22:0], si_s[1]});
    else if (mem_req && mem_ack)
      addr <= addr + 1'b1;
  end
  assign mem_addr = addr;

  // Output shifter; each bit changes on a falling edge
  always_ff @(posedge clk)
  begin
    if (!nrst || !sel)
    begin
      out_cnt <= '0;
      out_byte <= '0;
      so <= 1'b0;
      so_oe <= 1'b0;
    end
    else if (data_phase && fall)
    begin
      out_cnt <= out_cnt + 3'h1;
      so_oe <= f_out_valid || out_cnt != 3'h0;
      if (out_cnt == 3'h0)
      begin
        out_byte <= {f_out_data[6:0], 1'b0};
        so <= f_out_data[7];
      end
      else
      begin
        out_byte <= {out_byte[6:0], 1'b0};
        so <= out_byte[7];
      end
    end
  end
  // Write latch, busy cycle and register updates
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      write_latch_bit <= 1'b0;
      busy <= 1'b0;
      tw_cnt <= '0;
      sr_bits <= '0;
      config_reg <= '0;
      config2_reg <= '0;
      security_reg <= '0;
      pend_sr <= '0;
      pend_cr <= '0;
      pend_sr_wr <= 1'b0;
      pend_cr_wr <= 1'b0;
      cmd_rejected <= 1'b0;
    end
    else
    begin
      cmd_rejected <= 1'b0;
      if (cs_rise && opcode == OP_WRITE_LATCH_SET_CMD && sec_ok && !busy)
        write_latch_bit <= 1'b1;
      if (end_write)
      begin
        if (!busy && (good_sr || good_cr2 || good_sec))
        begin
          busy <= 1'b1;
          tw_cnt <= '0;
          // Capture now: later frames reuse the shifter during the cycle
          pend_sr <= (nbits == FRWAR_BITS_SR1) ? shreg[7:0] : shreg[15:8];
          pend_cr <= shreg[7:0];
          pend_sr_wr <= good_sr;
          pend_cr_wr <= good_sr && nbits == FRWAR_BITS_SR2;
          if (good_cr2 && shreg[31:8] == CR2_ADDR[23:0])
            config2_reg <= shreg[7:0];
          if (good_sec)
            security_reg[FRWAR_SEC_LOCK] <= 1'b1;
        end
        else
        begin
          cmd_rejected <= 1'b1;
          if (wr_cr2)
            write_latch_bit <= 1'b0;
        end
      end
      if (busy)
        tw_cnt <= tw_cnt + 32'h1;
      if (tw_done)
      begin
        busy <= 1'b0;
        write_latch_bit <= 1'b0;
        pend_sr_wr <= 1'b0;
        pend_cr_wr <= 1'b0;
        if (pend_sr_wr)
          sr_bits <= pend_sr & FRWAR_SR_WMASK;
        if (pend_cr_wr)
          config_reg <= pend_cr;
      end
    end
  end
  // Busy and latch bits are never taken from written data
  assign status_reg = {sr_bits[7:2], write_latch_bit, busy};
endmodule
`default_nettype wire

// ---- tb/frwar_checker.sv ----
// Assertion checker for the flash command block, bound to its top module
`default_nettype none
module frwar_checker #(
  parameter int TW_CYC = 8000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Serial pins
  input wire logic cs_n,
  input wire logic so_oe,
  // Registers and events
  input wire logic [7:0] status_reg,
  input wire logic [7:0] config2_reg,
  input wire logic [7:0] security_reg,
  input wire logic cmd_rejected
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Length of the running busy period
  int busy_cnt;
  always_ff @(posedge clk)
  begin
    busy_cnt <= (nrst && status_reg[0]) ? busy_cnt + 1 : 0;
  end
  // Select idle long enough to pass the synchronisers
  sequence s_cs_idle;
    cs_n [*8];
  endsequence
  sequence s_busy_start;
    $rose(status_reg[0]);
  endsequence
  sequence s_busy_end;
    $fell(status_reg[0]);
  endsequence
  property p_rej_pulse;
    cmd_rejected |=> !cmd_rejected;
  endproperty
  a_rej_pulse: assert property (p_rej_pulse) else $error("reject pulse too long");
  property p_busy_wel;
    s_busy_start |-> $past(status_reg[1]);
  endproperty
  a_busy_wel: assert property (p_busy_wel) else $error("write cycle without latch");
  property p_busy_end;
    s_busy_end |-> !status_reg[1];
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("latch kept after cycle");
  // One cycle of slack covers the launch edge of the write cycle
  property p_busy_len;
    s_busy_end |-> busy_cnt >= TW_CYC - 1 && busy_cnt <= TW_CYC + 1;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy period length wrong");
  property p_sr_hold;
    $changed(status_reg[7:2]) |-> $fell(status_reg[0]);
  endproperty
  a_sr_hold: assert property (p_sr_hold) else $error("status bits changed mid cycle");
  property p_cfg2;
    $changed(config2_reg) |-> $past(status_reg[1]) ##[0:2] status_reg[0];
  endproperty
  a_cfg2: assert property (p_cfg2) else $error("config2 changed without write");
  property p_sec_keep;
    $past(security_reg[1]) |-> security_reg[1];
  endproperty
  a_sec_keep: assert property (p_sec_keep) else $error("lockdown bit cleared");
  property p_sec_wel;
    $changed(security_reg) |-> $past(status_reg[1]);
  endproperty
  a_sec_wel: assert property (p_sec_wel) else $error("security changed without latch");
  property p_oe_idle;
    s_cs_idle |-> !so_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("output driven while deselected");
endmodule
bind frwar_core frwar_checker #(.TW_CYC(TW_CYC)) u_chk (.clk(clk), .nrst(nrst), .cs_n(cs_n),
  .so_oe(so_oe), .status_reg(status_reg), .config2_reg(config2_reg),
  .security_reg(security_reg), .cmd_rejected(cmd_rejected));
`default_nettype wire

// ---- tb/frwar_mem_model.sv ----
// Array storage stand-in answering the block's read port
`default_nettype none
module frwar_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Read port
  input wire logic [25:0] mem_addr,
  input wire logic mem_req,
  output logic mem_ack,
  output logic [7:0] mem_data,
  // Answer pace
  input wire logic slow
);
  logic [1:0] wait_cnt;
  // Data is a sum of address bytes; off-ack the bus toggles so stale use shows
  always_ff @(posedge clk)
  begin
    mem_ack <= 1'b0;
    mem_data <= ~mem_data;
    if (!nrst)
    begin
      wait_cnt <= 2'h0;
      mem_data <= 8'h00;
    end
    else if (mem_req && !mem_ack)
    begin
      wait_cnt <= wait_cnt + 2'h1;
      if (wait_cnt >= (slow ? 2'h3 : 2'h0))
      begin
        wait_cnt <= 2'h0;
        mem_ack <= 1'b1;
        mem_data <= mem_addr[7:0] + mem_addr[15:8];
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/frwar_tb_top.sv ----
// Self-checking bench for the flash command block
`default_nettype none
module frwar_tb_top
  import frwar_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // Short write cycle keeps the run brief yet outlasts one read frame
  localparam int TW = 2000;
  localparam logic [31:0] CR2A = 32'h00000000;
  logic clk, nrst, sclk, cs_n, si, so, so_oe, mode, ckerr, mem_req, mem_ack, slow, rej, oe_seen;
  logic [25:0] mem_addr;
  logic [7:0] mem_data, sr, d, e;
  logic [23:0] a;
  logic [15:0] lf;
  logic [63:0] rx;
  int n_mismatch, check_count, cyc;
  frwar_core #(.TW_CYC(TW), .CR2_ADDR(CR2A)) uut (.clk(clk), .nrst(nrst), .sclk(sclk),
    .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe), .octal_double_rate_mode(mode),
    .mem_addr(mem_addr), .mem_req(mem_req), .mem_ack(mem_ack), .mem_data(mem_data),
    .status_reg(), .config_reg(), .config2_reg(), .security_reg(),
    .checksum_error_bit(ckerr), .cmd_rejected());
  frwar_mem_model u_mem (.clk(clk), .nrst(nrst), .mem_addr(mem_addr), .mem_req(mem_req),
    .mem_ack(mem_ack), .mem_data(mem_data), .slow(slow));
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Sticky event flags and hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (uut.cmd_rejected === 1'b1) rej = 1'b1;
    if (so_oe === 1'b1) oe_seen = 1'b1;
    if (cyc == 60000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end
  function automatic logic [7:0] step();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf[7:0];
  endfunction
  function automatic logic [7:0] fm(input logic [25:0] x);
    return x[7:0] + x[15:8];
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask
  // One select-low frame: nb bits sent MSB first, then nr bits read at sclk rise
  task automatic frame(input logic [63:0] dat, input int nb, input int nr, input bit hi_end);
    rx = '0;
    rej = 1'b0;
    oe_seen = 1'b0;
    slow = ^step();
    cs_n = 1'b0;
    tick(8);
    for (int i = 0; i < nb + nr; i++)
    begin
      si = (i < nb) ? dat[nb - 1 - i] : ^step();
      tick(8);
      sclk = 1'b1;
      if (i >= nb) rx = {rx[62:0], so};
      tick(8);
      sclk = hi_end && i == nb + nr - 1;
    end
    tick(8);
    cs_n = 1'b1;
    tick(2);
    sclk = 1'b0;
    tick(8);
  endtask
  task automatic write_latch_set_cmd();
    frame(64'(FRWAR_OP_WRITE_LATCH_SET_CMD), 8, 0, 0);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 3000 && uut.status_reg[0] !== 1'b0; i++) tick(1);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    {nrst, sclk, si, mode, slow, rej, oe_seen} = '0;
    {cs_n, ckerr} = 2'b11;
    lf = 16'he057;
    tick(4);
    nrst = 1'b1;
    tick(4);
    chk({uut.status_reg, uut.config_reg, uut.config2_reg, uut.security_reg}, 0);
    d = step();
    frame({FRWAR_OP_STATUS_REG_WRITE_CMD, d}, 16, 0, 0);
    chk({rej, uut.status_reg}, 9'h100);
    write_latch_set_cmd();
    chk(uut.status_reg, 8'h02);
    e = step();
    frame({FRWAR_OP_STATUS_REG_WRITE_CMD, d, e}, 24, 0, 0);
    chk(uut.status_reg[1:0], 2'h3);
    frame(64'(FRWAR_OP_RDSR), 8, 8, 0);
    chk(rx[0], 1'b1);
    frame({FRWAR_OP_STATUS_REG_WRITE_CMD, ~d}, 16, 0, 0);
    chk({rej, uut.status_reg[1:0]}, 3'h7);
    wait_idle();
    sr = d & FRWAR_SR_WMASK;
    chk({uut.status_reg, uut.config_reg}, {sr, e});
    $display("test status done");
    write_latch_set_cmd();
    frame({FRWAR_OP_STATUS_REG_WRITE_CMD, ~d[7:4]}, 12, 0, 0);
    chk({rej, uut.status_reg}, {1'b1, sr | 8'h02});
    mode = 1'b1;
    frame({FRWAR_OP_STATUS_REG_WRITE_CMD, ~d}, 16, 0, 1);
    chk({rej, uut.status_reg}, {1'b1, sr | 8'h02});
    mode = 1'b0;
    $display("test reject done");
    frame(64'(FRWAR_OP_SECURITY_REG_WRITE_CMD), 8, 0, 0);
    chk({uut.status_reg[0], uut.security_reg}, 9'h102);
    frame(64'(FRWAR_OP_SECURITY_REG_READ_CMD), 8, 16, 0);
    chk(rx[15:0], 16'h0202);
    frame({FRWAR_OP_FRD3, 32'h0}, 40, 8, 0);
    chk({oe_seen, uut.status_reg[0]}, 2'h1);
    wait_idle();
    write_latch_set_cmd();
    frame({FRWAR_OP_SECURITY_REG_WRITE_CMD, 1'b0}, 9, 0, 0);
    chk(rej, 1'b1);
    write_latch_set_cmd();
    frame(64'(FRWAR_OP_SECURITY_REG_WRITE_CMD), 8, 0, 0);
    chk({rej, uut.security_reg}, 9'h102);
    $display("test security done");
    wait_idle();
    e = step();
    write_latch_set_cmd();
    frame({FRWAR_OP_SECOND_CONFIG_WRITE_CMD, CR2A, e}, 48, 0, 0);
    chk({uut.status_reg[0], uut.config2_reg}, {1'b1, e});
    frame({FRWAR_OP_SECOND_CONFIG_READ_CMD, CR2A}, 40, 8, 0);
    chk(rx[7], 1'b1);
    wait_idle();
    frame({FRWAR_OP_SECOND_CONFIG_READ_CMD, CR2A}, 40, 8, 0);
    chk(rx[7:0], e);
    write_latch_set_cmd();
    frame({FRWAR_OP_SECOND_CONFIG_WRITE_CMD, CR2A, ~e[7:4]}, 44, 0, 0);
    chk({rej, uut.status_reg[1], uut.config2_reg}, {2'b10, e});
    $display("test config2 done");
    a = {step(), step(), 8'hff};
    frame({FRWAR_OP_RD3, a}, 32, 16, 0);
    chk(rx[15:0], {fm(26'(a)), fm(26'(a) + 26'h1)});
    chk(mem_addr[25:24], 2'h0);
    frame({FRWAR_OP_FRD4, 32'h03ffffff, 8'h00}, 48, 16, 0);
    chk(rx[15:0], {fm(26'h3ffffff), fm(26'h0)});
    frame({FRWAR_OP_RD3, a}, 32, 4, 0);
    chk({oe_seen, so_oe}, 2'b10);
    $display("test array done");
    report_and_stop();
  end
endmodule
`default_nettype wire
